// [ldo_pkg.sv]
// constants shared by the status select top and its per-loop lock filter
// assumes a single 25 MHz clock and pins that are synchronised before use
package ldo_pkg;
   // serial control word: payload bits above a small word-select field
   localparam int PAYLOAD_W = 18;
   localparam int CTL_W = 2;
   localparam int SER_W = PAYLOAD_W + CTL_W;
   localparam logic [1:0] CTL_MAIN_R = 2'h0;
   localparam logic [1:0] CTL_AUX_R = 2'h1;
   // fields of the reference words
   localparam int SEL_HI = 17;
   localparam int SEL_LO = 14;
   localparam int OSC_BIT = 14;
   localparam int MAIN_POL_BIT = 14;
   localparam int AUX_POL_BIT = 15;
   localparam logic [PAYLOAD_W-1:0] WORD_RESET = 18'h00000;
   // select codes, upper three bits unless noted
   localparam logic [3:0] SEL_LOW = 4'h0;
   localparam logic [3:0] SEL_HIGH = 4'h1;
   localparam logic [2:0] SEL_MAIN_LOCK = 3'h1;
   localparam logic [2:0] SEL_AUX_LOCK = 3'h2;
   localparam logic [2:0] SEL_BOTH_LOCK = 3'h3;
   localparam logic [2:0] SEL_MAIN_REF = 3'h4;
   localparam logic [2:0] SEL_AUX_REF = 3'h5;
   localparam logic [2:0] SEL_MAIN_DIV = 3'h6;
   localparam logic [2:0] SEL_AUX_DIV = 3'h7;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int NARROW_WIN_NS = 15;
   localparam int WIDE_WIN_NS = 30;
   localparam int NARROW_CYC = (NARROW_WIN_NS / CLK_PERIOD_NS > 0) ?
      NARROW_WIN_NS / CLK_PERIOD_NS : 1;
   localparam int WIDE_CYC = (WIDE_WIN_NS / CLK_PERIOD_NS > 0) ?
      WIDE_WIN_NS / CLK_PERIOD_NS : 1;
   localparam int LOCK_RUN = 4;
   localparam int ERR_W = 4;
   localparam int RUN_W = 3;
   // register map
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h1;
   localparam logic [3:0] REG_STATE = 4'h2;
   localparam logic [3:0] REG_SELECT = 4'h3;
   localparam logic [3:0] REG_AUX_W0 = 4'h4;
   localparam logic [3:0] REG_AUX_W1 = 4'h5;
   localparam logic [3:0] REG_AUX_W2 = 4'h6;
   localparam logic [3:0] REG_MAIN_W0 = 4'h7;
   localparam logic [3:0] REG_MAIN_W1 = 4'h8;
   localparam logic [3:0] REG_MAIN_W2 = 4'h9;
   localparam int EV_W = 4;
   // pin synchroniser slots
   localparam int NIN = 9;
   localparam int IN_SCLK = 0;
   localparam int IN_SDATA = 1;
   localparam int IN_SLE = 2;
   localparam int IN_REF0 = 3;
   localparam int IN_DIV0 = 5;
   localparam int IN_PD0 = 7;
endpackage

// [ldo_lock_filter.sv]
// phase detector with anti-backlash pulses and digital lock filter, one loop
// assumes one-cycle edge pulses and a powerdown level already synchronised
module ldo_lock_filter
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ref_rise,
   input wire logic div_rise,
   input wire logic polarity,
   input wire logic powerdown,
   output logic pump_up,
   output logic pump_dn,
   output logic lock
);
   logic up;
   logic dn;
   logic done;
   logic [ldo_pkg::ERR_W-1:0] err;
   logic [ldo_pkg::RUN_W-1:0] run;
   logic narrow_ok;
   logic wide_bad;
   localparam logic [ldo_pkg::ERR_W-1:0] ERR_W_ONE = 4'h1;

   assign done = up & dn;
   assign narrow_ok = err <= ldo_pkg::ERR_W'(ldo_pkg::NARROW_CYC);
   assign wide_bad = err > ldo_pkg::ERR_W'(ldo_pkg::WIDE_CYC);

   // both sides held for one cycle before clearing: the minimum pulse in lock
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         up <= 1'b0;
         dn <= 1'b0;
      end
      else if (done)
      begin
         up <= 1'b0;
         dn <= 1'b0;
      end
      else
      begin
         if (ref_rise)
            up <= 1'b1;
         if (div_rise)
            dn <= 1'b1;
      end
   end

   // edges landing in the clearing cycle are lost; at 25 MHz that is rare
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pump_up <= 1'b0;
         pump_dn <= 1'b0;
      end
      else
      begin
         pump_up <= polarity ? up : dn;
         pump_dn <= polarity ? dn : up;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         err <= '0;
      else if (done)
         err <= '0;
      else if ((up ^ dn) && (err != '1))
         err <= err + ERR_W_ONE;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock <= 1'b0;
         run <= '0;
      end
      else if (powerdown)
      begin
         lock <= 1'b0;
         run <= '0;
      end
      else if (lock)
      begin
         run <= '0;
         if (wide_bad)
            lock <= 1'b0;
      end
      else if (done)
      begin
         if (!narrow_ok)
            run <= '0;
         else if (run == ldo_pkg::RUN_W'(ldo_pkg::LOCK_RUN - 1))
         begin
            lock <= 1'b1;
            run <= '0;
         end
         else
            run <= run + 3'h1;
      end
   end

   AST_PD_UNLOCK: assert property (@(posedge clk) disable iff (!rst_n)
      powerdown |=> !lock)
      else $error("lock high after powerdown");
   AST_RUN_OF_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(lock) |-> $past(done) && $past(narrow_ok)
         && $past(run) == ldo_pkg::RUN_W'(ldo_pkg::LOCK_RUN - 1))
      else $error("lock set without a full good run");
   AST_WIDE_DROP: assert property (@(posedge clk) disable iff (!rst_n)
      (lock && wide_bad) |=> !lock)
      else $error("lock kept past wide window");
   AST_WIDE_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (lock && !wide_bad && !powerdown) |=> lock)
      else $error("lock dropped inside wide window");
   AST_BAD_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
      (!lock && done && !narrow_ok) |=> run == '0 && !lock)
      else $error("bad cycle did not clear run");
   AST_MIN_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
      done |=> pump_up && pump_dn ##1 !(pump_up && pump_dn))
      else $error("compare pulse not one cycle on both pumps");
endmodule

// [ldo_status_select.sv]
// status pin select, oscillator mode and lock detect for a dual synthesizer
// assumes a host on the three-wire serial pins and software on the reg port
// Notes on behaviour
// - select bits 17..14 of aux word: 0 low, 1 high, lock codes
// - upper select 100 main reference output, 101 aux reference output
// - upper select 110 main N counter output, 111 aux N counter output
// - lock set after four consecutive reference cycles inside narrow window
// - once locked the wide figure applies; at 40 ns both windows round to one cycle
// - locked loop unlocks as soon as error exceeds wide window
// - powered-down loop holds its lock flag low
// - constant-level select codes force crystal oscillator mode
// - otherwise bit 14 picks mode: 0 logic, 1 crystal
// - data valid at serial clock rise; device shifts on that rise
// - locked loop still emits minimum up and down pump pulses
//
// Chosen here: the address map and the plain strobed port.
module ldo_status_select
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ser_clk_pin,
   input wire logic ser_data_pin,
   input wire logic ser_latch_pin,
   input wire logic main_reference_phase_input,
   input wire logic aux_reference_phase_input,
   input wire logic main_divider_phase_input,
   input wire logic aux_divider_phase_input,
   input wire logic main_powerdown,
   input wire logic aux_powerdown,
   input wire logic [ldo_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ldo_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ldo_pkg::DATA_W-1:0] reg_rdata,
   output logic irq,
   output logic status_mux_pin,
   output logic osc_crystal_mode,
   output logic main_charge_pump_up,
   output logic main_charge_pump_dn,
   output logic aux_charge_pump_up,
   output logic aux_charge_pump_dn
);
   // constant levels on the status pin also force crystal mode
   function automatic logic sel_is_const(input logic [3:0] s);
      sel_is_const = (s == ldo_pkg::SEL_LOW) || (s == ldo_pkg::SEL_HIGH);
   endfunction

   logic [ldo_pkg::NIN-1:0] pins;
   logic [ldo_pkg::NIN-1:0] s1;
   logic [ldo_pkg::NIN-1:0] s2;
   logic [ldo_pkg::NIN-1:0] s3;
   logic [ldo_pkg::NIN-1:0] filt;
   logic [ldo_pkg::NIN-1:0] filt_d;
   logic [ldo_pkg::NIN-1:0] rise;
   logic [ldo_pkg::SER_W-1:0] shift;
   logic [ldo_pkg::PAYLOAD_W-1:0] aux_word;
   logic [ldo_pkg::PAYLOAD_W-1:0] main_word;
   logic [3:0] sel;
   logic [1:0] lock;
   logic [1:0] pol;
   logic [1:0] pump_up;
   logic [1:0] pump_dn;
   logic [1:0] lock_d;
   logic [ldo_pkg::EV_W-1:0] status;
   logic [ldo_pkg::EV_W-1:0] mask;
   logic [ldo_pkg::EV_W-1:0] events;
   logic [ldo_pkg::EV_W-1:0] clear;
   logic [ldo_pkg::DATA_W-1:0] next_rdata;
   logic next_mux;

   assign pins = {aux_powerdown, main_powerdown,
                  aux_divider_phase_input, main_divider_phase_input,
                  aux_reference_phase_input, main_reference_phase_input,
                  ser_latch_pin, ser_data_pin, ser_clk_pin};

   // three stages; a level is taken only once stages two and three agree,
   // which rejects a single-cycle glitch at the cost of two cycles latency
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else
      begin
         s1 <= pins;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         filt <= '0;
         filt_d <= '0;
      end
      else
      begin
         filt <= (filt & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
         filt_d <= filt;
      end
   end

   assign rise = filt & ~filt_d;

   // serial word, msb first into the low end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         shift <= '0;
      else if (rise[ldo_pkg::IN_SCLK])
         shift <= {shift[ldo_pkg::SER_W-2:0], filt[ldo_pkg::IN_SDATA]};
   end

   // latch rise moves the payload into the word named by the select field
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_word <= ldo_pkg::WORD_RESET;
         main_word <= ldo_pkg::WORD_RESET;
      end
      else if (rise[ldo_pkg::IN_SLE])
      begin
         if (shift[ldo_pkg::CTL_W-1:0] == ldo_pkg::CTL_AUX_R)
            aux_word <= shift[ldo_pkg::SER_W-1:ldo_pkg::CTL_W];
         if (shift[ldo_pkg::CTL_W-1:0] == ldo_pkg::CTL_MAIN_R)
            main_word <= shift[ldo_pkg::SER_W-1:ldo_pkg::CTL_W];
      end
   end

   assign sel = aux_word[ldo_pkg::SEL_HI:ldo_pkg::SEL_LO];
   assign pol = {main_word[ldo_pkg::AUX_POL_BIT], main_word[ldo_pkg::MAIN_POL_BIT]};

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : loop
         ldo_lock_filter u_filter
         (
            .clk(clk),
            .rst_n(rst_n),
            .ref_rise(rise[ldo_pkg::IN_REF0 + g]),
            .div_rise(rise[ldo_pkg::IN_DIV0 + g]),
            .polarity(pol[g]),
            .powerdown(filt[ldo_pkg::IN_PD0 + g]),
            .pump_up(pump_up[g]),
            .pump_dn(pump_dn[g]),
            .lock(lock[g])
         );
      end
   endgenerate

   assign main_charge_pump_up = pump_up[0];
   assign main_charge_pump_dn = pump_dn[0];
   assign aux_charge_pump_up = pump_up[1];
   assign aux_charge_pump_dn = pump_dn[1];

   // status pin source; bit 14 only matters for the two constant codes
   always_comb
   begin
      next_mux = 1'b0;
      case (sel[3:1])
         3'h0: next_mux = sel[0];
         ldo_pkg::SEL_MAIN_LOCK: next_mux = lock[0];
         ldo_pkg::SEL_AUX_LOCK: next_mux = lock[1];
         ldo_pkg::SEL_BOTH_LOCK: next_mux = lock[0] & lock[1];
         ldo_pkg::SEL_MAIN_REF: next_mux = filt[ldo_pkg::IN_REF0];
         ldo_pkg::SEL_AUX_REF: next_mux = filt[ldo_pkg::IN_REF0 + 1];
         ldo_pkg::SEL_MAIN_DIV: next_mux = filt[ldo_pkg::IN_DIV0];
         ldo_pkg::SEL_AUX_DIV: next_mux = filt[ldo_pkg::IN_DIV0 + 1];
         default: next_mux = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status_mux_pin <= 1'b0;
      else
         status_mux_pin <= next_mux;
   end

   // reset lands on select zero, so the oscillator starts in crystal mode
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         osc_crystal_mode <= 1'b1;
      else if (sel_is_const(sel))
         osc_crystal_mode <= 1'b1;
      else
         osc_crystal_mode <= aux_word[ldo_pkg::OSC_BIT];
   end

   // lock gained and lost events per loop
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_d <= '0;
      else
         lock_d <= lock;
   end

   assign events = {lock_d & ~lock, lock & ~lock_d};
   assign clear = (reg_wr && reg_addr == ldo_pkg::REG_STATUS) ?
      reg_wdata[ldo_pkg::EV_W-1:0] : '0;

   // a new event wins over a write-one-clear in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status <= '0;
      else
         status <= (status & ~clear) | events;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mask <= '0;
      else if (reg_wr && reg_addr == ldo_pkg::REG_MASK)
         mask <= reg_wdata[ldo_pkg::EV_W-1:0];
   end

   assign irq = |(status & mask);

   always_comb
   begin
      next_rdata = '0;
      case (reg_addr)
         ldo_pkg::REG_STATUS: next_rdata = {4'h0, status};
         ldo_pkg::REG_MASK: next_rdata = {4'h0, mask};
         ldo_pkg::REG_STATE: next_rdata = {3'h0, pol, osc_crystal_mode, lock};
         ldo_pkg::REG_SELECT: next_rdata = {4'h0, sel};
         ldo_pkg::REG_AUX_W0: next_rdata = aux_word[7:0];
         ldo_pkg::REG_AUX_W1: next_rdata = aux_word[15:8];
         ldo_pkg::REG_AUX_W2: next_rdata = {6'h00, aux_word[17:16]};
         ldo_pkg::REG_MAIN_W0: next_rdata = main_word[7:0];
         ldo_pkg::REG_MAIN_W1: next_rdata = main_word[15:8];
         ldo_pkg::REG_MAIN_W2: next_rdata = {6'h00, main_word[17:16]};
         default: next_rdata = '0;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= '0;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= '0;
   end

   AST_MUX_CONST: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == 3'h0) |=> status_mux_pin == $past(sel[0]))
      else $error("constant select level wrong");
   AST_MUX_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == ldo_pkg::SEL_BOTH_LOCK) |=> status_mux_pin == $past(&lock))
      else $error("and of locks wrong on status pin");
   AST_MUX_AUX_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == ldo_pkg::SEL_AUX_LOCK) |=> status_mux_pin == $past(lock[1]))
      else $error("aux lock wrong on status pin");
   AST_MUX_REF: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == ldo_pkg::SEL_AUX_REF)
         |=> status_mux_pin == $past(filt[ldo_pkg::IN_REF0 + 1]))
      else $error("aux reference output wrong on status pin");
   AST_MUX_DIV: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == ldo_pkg::SEL_MAIN_DIV)
         |=> status_mux_pin == $past(filt[ldo_pkg::IN_DIV0]))
      else $error("main divider output wrong on status pin");
   AST_OSC_FORCE: assert property (@(posedge clk) disable iff (!rst_n)
      sel_is_const(sel) |=> osc_crystal_mode)
      else $error("crystal mode not forced");
   AST_OSC_BIT: assert property (@(posedge clk) disable iff (!rst_n)
      !sel_is_const(sel) |=> osc_crystal_mode == $past(aux_word[ldo_pkg::OSC_BIT]))
      else $error("oscillator mode does not follow bit 14");
   AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!rst_n)
      rise[ldo_pkg::IN_SCLK] |=> shift[0] == $past(filt[ldo_pkg::IN_SDATA])
         && shift[ldo_pkg::SER_W-1:1] == $past(shift[ldo_pkg::SER_W-2:0]))
      else $error("serial bit not shifted on clock rise");
   AST_PD_PIN: assert property (@(posedge clk) disable iff (!rst_n)
      (filt[ldo_pkg::IN_PD0] && sel[3:1] == ldo_pkg::SEL_MAIN_LOCK)
         |=> ##1 !status_mux_pin)
      else $error("powered-down main loop shows lock");
   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
      (|(events & mask)) && !(reg_wr && reg_addr == ldo_pkg::REG_MASK)
         |=> irq)
      else $error("unmasked event did not raise the interrupt");
   AST_READ_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == '0)
      else $error("read data outside its cycle");
   // routes that the checks above leave open
   AST_MUX_MAIN_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == ldo_pkg::SEL_MAIN_LOCK) |=> status_mux_pin == $past(lock[0]))
      else $error("main lock wrong on status pin");
   AST_MUX_MAIN_REF: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == ldo_pkg::SEL_MAIN_REF)
         |=> status_mux_pin == $past(filt[ldo_pkg::IN_REF0]))
      else $error("main reference output wrong on status pin");
   AST_MUX_AUX_DIV: assert property (@(posedge clk) disable iff (!rst_n)
      (sel[3:1] == ldo_pkg::SEL_AUX_DIV)
         |=> status_mux_pin == $past(filt[ldo_pkg::IN_DIV0 + 1]))
      else $error("aux divider output wrong on status pin");
   AST_PD_PIN_AUX: assert property (@(posedge clk) disable iff (!rst_n)
      (filt[ldo_pkg::IN_PD0 + 1] && sel[3:1] == ldo_pkg::SEL_BOTH_LOCK)
         |=> ##1 !status_mux_pin)
      else $error("powered-down aux loop shows lock");
   // pin filter, serial path and word loads
   AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (!rst_n)
      ((filt ^ $past(filt)) & ($past(s2) ^ $past(s3))) == '0)
      else $error("pin level taken before stages two and three agree");
   AST_SHIFT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !rise[ldo_pkg::IN_SCLK] |=> $stable(shift))
      else $error("shift register moved without a serial clock rise");
   AST_AUX_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      (rise[ldo_pkg::IN_SLE] && shift[ldo_pkg::CTL_W-1:0] == ldo_pkg::CTL_AUX_R)
         |=> aux_word == $past(shift[ldo_pkg::SER_W-1:ldo_pkg::CTL_W]))
      else $error("aux word not loaded on latch rise");
   AST_MAIN_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      (rise[ldo_pkg::IN_SLE] && shift[ldo_pkg::CTL_W-1:0] == ldo_pkg::CTL_MAIN_R)
         |=> main_word == $past(shift[ldo_pkg::SER_W-1:ldo_pkg::CTL_W]))
      else $error("main word not loaded on latch rise");
   // event flags and register port
   AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
      (|events) |=> (status & $past(events)) == $past(events))
      else $error("event lost against a clear");
   AST_CLEAR_W1C: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == ldo_pkg::REG_STATUS && !(|events))
         |=> (status & $past(reg_wdata[ldo_pkg::EV_W-1:0])) == '0)
      else $error("write one did not clear status");
   AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == ldo_pkg::REG_MASK)
         |=> mask == $past(reg_wdata[ldo_pkg::EV_W-1:0]))
      else $error("mask write not taken");
   AST_READ_DATA: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd |=> reg_rdata == $past(next_rdata))
      else $error("read data not presented in the cycle after the strobe");
endmodule

// [ldo_host_model.sv]
// host model: loads control words over the three-wire serial pins
// assumes one caller at a time and the block's clock as the pacing reference
module ldo_host_model
(
   input wire logic clk,
   output logic ser_clk,
   output logic ser_data,
   output logic ser_latch
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch = 1'b0;
   end
   // every level lasts at least 4 clocks so the pin filter cannot drop it
   task automatic send_word(input logic [1:0] ctl, input logic [17:0] payload);
      logic [19:0] frame;
      frame = {payload, ctl};
      for (int i = 19; i >= 0; i--)
      begin
         @(posedge clk);
         ser_data <= frame[i];
         repeat (4) @(posedge clk);
         ser_clk <= 1'b1;
         repeat (4) @(posedge clk);
         ser_clk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      ser_latch <= 1'b1;
      repeat (4) @(posedge clk);
      ser_latch <= 1'b0;
      // released data line shows the inverse so a stale bit cannot pass
      ser_data <= ~frame[0];
   endtask
endmodule

// [tb.sv]
// self-checking bench for the status select block
// assumes the host model drives the serial pins and the bench the rest
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, sdata, slatch;
   logic mref = 1'b0, aref = 1'b0, mdiv = 1'b0, adiv = 1'b0, mpd = 1'b0;
   logic apd = 1'b0, pair = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0, rd = 1'b0;
   logic [7:0] rdata, d;
   logic irq, pin, osc, mup, mdn, aup, adn;
   int both_cnt = 0;
   int pulse_base = 0;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;

   initial
      forever #20 clk = ~clk;

   ldo_host_model ldo_host_model_inst (.clk(clk), .ser_clk(sclk), .ser_data(sdata),
      .ser_latch(slatch));

   ldo_status_select ldo_status_select_inst (.clk(clk), .rst_n(rst_n), .ser_clk_pin(sclk),
      .ser_data_pin(sdata), .ser_latch_pin(slatch), .main_reference_phase_input(mref),
      .aux_reference_phase_input(aref), .main_divider_phase_input(mdiv),
      .aux_divider_phase_input(adiv), .main_powerdown(mpd), .aux_powerdown(apd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .irq(irq), .status_mux_pin(pin), .osc_crystal_mode(osc),
      .main_charge_pump_up(mup), .main_charge_pump_dn(mdn),
      .aux_charge_pump_up(aup), .aux_charge_pump_dn(adn));

   always @(posedge clk)
      if (mup === 1'b1 && mdn === 1'b1)
         both_cnt <= both_cnt + 1;

   task automatic finish_test();
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ceiling well above the roughly 4200 cycles the sequence needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         err_total++;
         finish_test();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask

   task automatic set_sel(input logic [3:0] code);
      ldo_host_model_inst.send_word(ldo_pkg::CTL_AUX_R, {code, 14'h0000});
      repeat (10) @(posedge clk);
      @(negedge clk);
   endtask

   // one reference cycle; gap is the lag of the divider edge in clocks,
   // and pair lets the aux loop see the same edges
   task automatic phase_cycle(input int gap);
      @(posedge clk);
      mref <= 1'b1;
      aref <= pair;
      repeat (gap) @(posedge clk);
      mdiv <= 1'b1;
      adiv <= pair;
      repeat (4) @(posedge clk);
      mref <= 1'b0;
      mdiv <= 1'b0;
      aref <= 1'b0;
      adiv <= 1'b0;
      repeat (12) @(posedge clk);
      @(negedge clk);
   endtask

   function automatic logic exp_pin(input logic [3:0] c);
      case (c[3:1])
         3'h0: return c[0];
         ldo_pkg::SEL_MAIN_REF: return mref;
         ldo_pkg::SEL_AUX_REF: return aref;
         ldo_pkg::SEL_MAIN_DIV: return mdiv;
         ldo_pkg::SEL_AUX_DIV: return adiv;
         default: return 1'b0;
      endcase
   endfunction

   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check({7'h00, pin}, 8'h00, "pin after reset");
      check({7'h00, osc}, 8'h01, "osc after reset");
      // distinct static levels so main and aux of each input pair are told apart
      @(posedge clk);
      mref <= 1'b1;
      adiv <= 1'b1;
      // both oscillator modes are loaded, as a host would for either source
      for (int c = 0; c < 16; c++)
      begin
         set_sel(c[3:0]);
         check({7'h00, pin}, {7'h00, exp_pin(c[3:0])}, "status pin");
         check({7'h00, osc}, {7'h00, (c < 2) ? 1'b1 : c[0]}, "osc mode");
      end
      // polarity zero swaps: lone reference edge pumps down, lone divider edge up
      check({6'h00, mup, mdn}, 8'h01, "main pumps with reference leading");
      check({6'h00, aup, adn}, 8'h02, "aux pumps with divider leading");
      @(posedge clk);
      mref <= 1'b0;
      adiv <= 1'b0;
      set_sel(4'h2);
      repeat (3) phase_cycle(0);
      phase_cycle(3);
      repeat (3) phase_cycle(0);
      check({7'h00, pin}, 8'h00, "lock after broken run");
      phase_cycle(0);
      check({7'h00, pin}, 8'h01, "lock after four good");
      reg_read(ldo_pkg::REG_STATE, d);
      check({7'h00, d[0]}, 8'h01, "state main lock");
      check({7'h00, irq}, 8'h00, "irq masked");
      reg_read(ldo_pkg::REG_STATUS, d);
      check(d, 8'h01, "status gained");
      pulse_base = both_cnt;
      phase_cycle(0);
      check(8'(both_cnt - pulse_base), 8'h01, "one minimum pulse while locked");
      check({7'h00, pin}, 8'h01, "lock held");
      reg_write(ldo_pkg::REG_MASK, 8'h01);
      @(negedge clk);
      check({7'h00, irq}, 8'h01, "irq unmasked");
      reg_write(ldo_pkg::REG_STATUS, 8'h01);
      @(negedge clk);
      check({7'h00, irq}, 8'h00, "irq cleared");
      phase_cycle(3);
      check({7'h00, pin}, 8'h00, "unlock on large error");
      reg_read(ldo_pkg::REG_STATUS, d);
      check(d, 8'h04, "status lost");
      check({7'h00, irq}, 8'h00, "lost event masked");
      repeat (4) phase_cycle(0);
      check({7'h00, pin}, 8'h01, "relock");
      @(posedge clk);
      mpd <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      check({7'h00, pin}, 8'h00, "powerdown drops lock");
      phase_cycle(0);
      check({7'h00, pin}, 8'h00, "powerdown holds lock low");
      // aux joins in; its stale first compare must restart its run
      @(posedge clk);
      mpd <= 1'b0;
      pair <= 1'b1;
      set_sel(4'h6);
      repeat (4) phase_cycle(0);
      check({7'h00, pin}, 8'h00, "and code while aux still counting");
      phase_cycle(0);
      check({7'h00, pin}, 8'h01, "and of both locks");
      @(posedge clk);
      apd <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      check({7'h00, pin}, 8'h00, "aux powerdown drops lock");
      ldo_host_model_inst.send_word(ldo_pkg::CTL_MAIN_R, 18'h0C000);
      repeat (10) @(posedge clk);
      reg_read(ldo_pkg::REG_STATE, d);
      check(d, 8'h19, "polarity bits, logic mode, main lock");
      reg_read(ldo_pkg::REG_MAIN_W1, d);
      check(d, 8'hC0, "main word middle byte");
      reg_read(ldo_pkg::REG_SELECT, d);
      check(d, 8'h06, "select field");
      reg_read(4'hF, d);
      check(d, 8'h00, "unmapped read");
      @(negedge clk);
      check(rdata, 8'h00, "read data after its cycle");
      finish_test();
   end
endmodule
